/* logic/rfs_regs.vh */
`ifndef RFS_REGS_VH
`define RFS_REGS_VH
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define RFS_ADDR_CTRL     8'h00
`define RFS_ADDR_STATUS   8'h04
`define RFS_ADDR_IRQ_STAT 8'h08
`define RFS_ADDR_IRQ_MASK 8'h0c
`define RFS_ADDR_THRESH   8'h10
// ----------------------------------------
// Event bit positions
// ----------------------------------------
`define RFS_EV_OC    0
`define RFS_EV_WOC   1
`define RFS_EV_BAL   2
`define RFS_EV_UV    3
`define RFS_EV_OV1   4
`define RFS_EV_OV2   5
`define RFS_EV_TT    6
`define RFS_NEV      7
`define RFS_MASK_RST 7'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define RFS_CLK_MHZ     24'd100
`define RFS_OC_TIME_US  24'd120
`define RFS_LONG_TIME_US 24'd1000
`define RFS_OC_CYC   (`RFS_OC_TIME_US * `RFS_CLK_MHZ)
`define RFS_LONG_CYC (`RFS_LONG_TIME_US * `RFS_CLK_MHZ)
`endif

/* logic/rfs_persist_timer.v */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Persistence timer: fires when cond holds limit cycles
// ----------------------------------------
module rfs_persist_timer (
  input  wire        clk,
  input  wire        clr,
  input  wire        cond,
  input  wire [23:0] limit,
  output reg         expired
);
  reg [23:0] count;
  always @(posedge clk) begin
    if (clr || !cond) begin
      count   <= 24'h000000;
      expired <= 1'b0;
    end else if (count >= limit - 24'h000001) begin
      expired <= 1'b1;
    end else begin
      count <= count + 24'h000001;
    end
  end
endmodule
`default_nettype wire

/* logic/rfs_supervisor.v */
`timescale 1ns/1ps
`default_nettype none
`include "rfs_regs.vh"
module rfs_supervisor (
  input  wire        clk,
  input  wire        rst,
  input  wire        regulator_enable_in,
  input  wire        low_power_state_n,
  input  wire        deeper_sleep_select,
  input  wire [1:0]  phase_config,
  input  wire [2:0]  comp_range,
  input  wire        droop_above_oc,
  input  wire        droop_above_woc,
  input  wire        phase_current_sense_imbal,
  input  wire        out_under_target,
  input  wire        out_over_target,
  input  wire        out_above_1v55,
  input  wire        out_below_0v85,
  input  wire        ntc_below_1v18,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hsel,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  output reg         pwm_tristate,
  output reg         low_side_force_on,
  output reg         power_good_out,
  output reg         thermal_throttle_n,
  output reg         aux_feedback_node_sw,
  output reg  [8:0]  oc_threshold,
  output reg  [1:0]  active_phases,
  output reg         diode_emulation,
  output reg         irq
);
  // ----------------------------------------
  // Operating mode
  // ----------------------------------------
  reg [1:0] next_phases;
  always @* begin
    if (deeper_sleep_select) begin
      next_phases = 2'd1;
    end else if (!low_power_state_n && phase_config != 2'd1) begin
      next_phases = phase_config - 2'd1;
    end else begin
      next_phases = phase_config;
    end
  end

  // ----------------------------------------
  // Threshold table, quarter-uA units
  // ----------------------------------------
  reg [2:0]  heldRange;
  reg        rangeValid;
  reg [8:0]  thrOne;
  reg [8:0]  thrTwo;
  reg [8:0]  thrThree;
  always @* begin
    case (heldRange)
      3'd1: begin
        thrOne   = 9'h05b;
        thrTwo   = 9'h0b5;
        thrThree = 9'h110;
      end
      3'd2: begin
        thrOne   = 9'h053;
        thrTwo   = 9'h0a5;
        thrThree = 9'h0f8;
      end
      3'd3: begin
        thrOne   = 9'h048;
        thrTwo   = 9'h090;
        thrThree = 9'h0d8;
      end
      3'd4: begin
        thrOne   = 9'h050;
        thrTwo   = 9'h095;
        thrThree = 9'h0e0;
      end
      3'd5: begin
        thrOne   = 9'h05b;
        thrTwo   = 9'h09b;
        thrThree = 9'h0e8;
      end
      3'd6: begin
        thrOne   = 9'h053;
        thrTwo   = 9'h0ab;
        thrThree = 9'h100;
      end
      3'd7: begin
        thrOne   = 9'h048;
        thrTwo   = 9'h0b0;
        thrThree = 9'h108;
      end
      default: begin
        thrOne   = 9'h050;
        thrTwo   = 9'h0a0;
        thrThree = 9'h0f0;
      end
    endcase
  end
  // Mode columns already hold the 2/3 and 1/3 scaled levels, except the 1/3 column of ranges 4 to 7
  reg [8:0]  next_thr;
  always @* begin
    case (next_phases)
      2'd3:    next_thr = thrThree;
      2'd2:    next_thr = thrTwo;
      default: next_thr = thrOne;
    endcase
  end

  // ----------------------------------------
  // Start-up capture and fault-latch state
  // ----------------------------------------
  localparam ST_OFF = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_LAT = 3'b100;
  reg  [2:0] state;
  reg        ov2Latch;
  reg        ov2Force;
  wire [`RFS_NEV-1:0] hit;
  wire       clrFaults = !regulator_enable_in;
  wire       anyLatch  = hit[`RFS_EV_OC] | droop_above_woc | hit[`RFS_EV_BAL]
                         | hit[`RFS_EV_UV] | hit[`RFS_EV_OV1];
  always @(posedge clk) begin
    if (rst) begin
      state      <= ST_OFF;
      heldRange  <= 3'd0;
      rangeValid <= 1'b0;
    end else begin
      case (state)
        ST_OFF: begin
          if (regulator_enable_in) begin
            heldRange  <= comp_range;
            rangeValid <= 1'b1;
            state      <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (clrFaults) begin
            state      <= ST_OFF;
            rangeValid <= 1'b0;
          end else if (anyLatch) begin
            state <= ST_LAT;
          end
        end
        ST_LAT: begin
          if (clrFaults) begin
            state      <= ST_OFF;
            rangeValid <= 1'b0;
          end
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  // ----------------------------------------
  // Persistence timers
  // ----------------------------------------
  wire [23:0] ocLim   = `RFS_OC_CYC;
  wire [23:0] longLim = `RFS_LONG_CYC;
  wire        running = (state == ST_RUN);
  rfs_persist_timer u_oc (
    .clk(clk), .clr(rst || !running), .cond(droop_above_oc),
    .limit(ocLim), .expired(hit[`RFS_EV_OC])
  );
  rfs_persist_timer u_bal (
    .clk(clk), .clr(rst || !running || phase_config == 2'd1),
    .cond(phase_current_sense_imbal), .limit(longLim), .expired(hit[`RFS_EV_BAL])
  );
  rfs_persist_timer u_uv (
    .clk(clk), .clr(rst || !running), .cond(out_under_target),
    .limit(longLim), .expired(hit[`RFS_EV_UV])
  );
  rfs_persist_timer u_ov1 (
    .clk(clk), .clr(rst || !running), .cond(out_over_target),
    .limit(longLim), .expired(hit[`RFS_EV_OV1])
  );
  assign hit[`RFS_EV_WOC] = running & droop_above_woc;
  assign hit[`RFS_EV_OV2] = regulator_enable_in & out_above_1v55 & !ov2Force;
  assign hit[`RFS_EV_TT]  = ntc_below_1v18 & thermal_throttle_n;

  // ----------------------------------------
  // Second-level overvoltage
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      ov2Latch <= 1'b0;
      ov2Force <= 1'b0;
    end else if (regulator_enable_in && out_above_1v55) begin
      ov2Latch <= 1'b1;
      ov2Force <= 1'b1;
    end else if (out_below_0v85) begin
      ov2Force <= 1'b0;
    end
  end

  // ----------------------------------------
  // Fault outputs
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      pwm_tristate       <= 1'b1;
      low_side_force_on  <= 1'b0;
      power_good_out     <= 1'b0;
      thermal_throttle_n <= 1'b1;
    end else begin
      low_side_force_on  <= ov2Force | (regulator_enable_in & out_above_1v55);
      pwm_tristate       <= !running | anyLatch | ov2Latch;
      power_good_out     <= running & !anyLatch & !ov2Latch
                            & !(regulator_enable_in & out_above_1v55);
      thermal_throttle_n <= !ntc_below_1v18;
    end
  end

  // ----------------------------------------
  // Mode outputs
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      aux_feedback_node_sw <= 1'b0;
      oc_threshold         <= 9'h000;
      active_phases        <= 2'd0;
      diode_emulation      <= 1'b0;
    end else begin
      aux_feedback_node_sw <= (phase_config == 2'd2) && (next_phases == 2'd2);
      oc_threshold         <= rangeValid ? next_thr : 9'h000;
      active_phases        <= next_phases;
      diode_emulation      <= deeper_sleep_select;
    end
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  reg  [`RFS_NEV-1:0] irqStat;
  reg  [`RFS_NEV-1:0] irqMask;
  reg                 dValid;
  reg                 dWrite;
  reg  [7:0]          dAddr;
  wire                rdStat = dValid && !dWrite && dAddr == `RFS_ADDR_IRQ_STAT;
  always @(posedge clk) begin
    if (rst) begin
      irqStat <= {`RFS_NEV{1'b0}};
      irq     <= 1'b0;
    end else begin
      irqStat <= (rdStat ? {`RFS_NEV{1'b0}} : irqStat) | hit;
      irq     <= |(irqStat & irqMask);
    end
  end

  // ----------------------------------------
  // AHB-Lite address phase, zero wait states
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      dValid    <= 1'b0;
      dWrite    <= 1'b0;
      dAddr     <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dValid    <= hsel && hready && htrans[1];
      dWrite    <= hwrite;
      dAddr     <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------
  // Mask register, written in the data phase
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      irqMask <= `RFS_MASK_RST;
    end else if (dValid && dWrite && dAddr == `RFS_ADDR_IRQ_MASK) begin
      irqMask <= hwdata[`RFS_NEV-1:0];
    end
  end

  // ----------------------------------------
  // Read data, loaded at the address phase
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else begin
      if (hsel && hready && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          `RFS_ADDR_CTRL:     hrdata <= {27'h0, diode_emulation, active_phases,
                                         phase_config};
          `RFS_ADDR_STATUS:   hrdata <= {24'h0, state, ov2Force, ov2Latch,
                                         power_good_out, pwm_tristate, !thermal_throttle_n};
          `RFS_ADDR_IRQ_STAT: hrdata <= {25'h0, irqStat | hit};
          `RFS_ADDR_IRQ_MASK: hrdata <= {25'h0, irqMask};
          `RFS_ADDR_THRESH:   hrdata <= {20'h0, heldRange, oc_threshold};
          default:            hrdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* test/rfs_supervisor_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module rfs_supervisor_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic regulator_enable_in,
  input wire logic droop_above_woc,
  input wire logic out_above_1v55,
  input wire logic out_below_0v85,
  input wire logic ntc_below_1v18,
  input wire logic pwm_tristate,
  input wire logic low_side_force_on,
  input wire logic power_good_out,
  input wire logic thermal_throttle_n,
  input wire logic aux_feedback_node_sw,
  input wire logic [1:0] active_phases,
  input wire logic diode_emulation
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Fault responses and mode checks
  // ----------------------------------------
  sequence s_woc;
    regulator_enable_in && droop_above_woc ##1 regulator_enable_in;
  endsequence
  sequence s_ov2;
    regulator_enable_in && out_above_1v55 ##1 regulator_enable_in;
  endsequence
  property p_woc;
    s_woc |-> ##[0:1] (!power_good_out && pwm_tristate);
  endproperty
  property p_ov2;
    s_ov2 |-> ##[0:1] (low_side_force_on && !power_good_out);
  endproperty
  property p_rel;
    low_side_force_on && out_below_0v85 && !out_above_1v55
      |-> ##[1:2] (!low_side_force_on && pwm_tristate);
  endproperty
  property p_hold;
    low_side_force_on && !out_below_0v85 |=> low_side_force_on;
  endproperty
  property p_pg;
    low_side_force_on |-> !power_good_out;
  endproperty
  property p_tt;
    ntc_below_1v18 [*2] |-> !thermal_throttle_n;
  endproperty
  property p_tt_off;
    !ntc_below_1v18 [*2] |-> thermal_throttle_n;
  endproperty
  property p_de;
    diode_emulation |-> active_phases == 2'h1;
  endproperty
  property p_aux;
    aux_feedback_node_sw |-> active_phases == 2'h2;
  endproperty
  a_woc: assert property (p_woc) else $error("way overcurrent missed");
  a_ov2: assert property (p_ov2) else $error("overvoltage force missed");
  a_rel: assert property (p_rel) else $error("force not released");
  a_hold: assert property (p_hold) else $error("force dropped early");
  a_pg: assert property (p_pg) else $error("power good during force");
  a_tt: assert property (p_tt) else $error("throttle not asserted");
  a_tt_off: assert property (p_tt_off) else $error("throttle stuck");
  a_de: assert property (p_de) else $error("diode mode phases");
  a_aux: assert property (p_aux) else $error("aux switch phases");
endmodule
bind rfs_supervisor rfs_supervisor_sva u_sva (.clk, .rst, .regulator_enable_in,
  .droop_above_woc, .out_above_1v55, .out_below_0v85, .ntc_below_1v18, .pwm_tristate,
  .low_side_force_on, .power_good_out, .thermal_throttle_n, .aux_feedback_node_sw,
  .active_phases, .diode_emulation);
`default_nettype wire

/* test/rfs_vout_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rfs_vout_model (
  input  wire logic clk,
  input  wire logic hsShort,
  input  wire logic low_side_force_on,
  output var  logic out_above_1v55,
  output var  logic out_below_0v85
);
  int vMv = 1000;
  // Forced low sides pull down, a shorted high side pulls up
  always @(posedge clk) begin
    if (low_side_force_on) vMv <= (vMv > 50) ? vMv - 50 : 0;
    else if (hsShort) vMv <= (vMv < 1800) ? vMv + 50 : 1800;
  end
  assign out_above_1v55 = vMv > 1550;
  assign out_below_0v85 = vMv < 850;
endmodule
`default_nettype wire

/* test/regulator_fault_supervisor_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("Error %0t: %s", $time, m); end end
module regulator_fault_supervisor_test;
  logic clk, rst, en, psi, ds, oc, woc, imb, uv, ov, ntc, hsShort, hwrite, hsel;
  logic [1:0] cfg, htrans;
  logic [2:0] comp, hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic hreadyout, hresp, pwm, ls, pg, ttN, aux, de, irq, above, below, p;
  logic [8:0] thr;
  logic [1:0] ph;
  wire hready = hreadyout;
  int err_total, cmp_count, i, n;
  logic [16:0] rows [12] = '{17'h190a0, 17'h1ac50, 17'h1d8f0, 17'h1ec50, 17'h10850,
    17'h12c50, 17'h152a0, 17'h16c50, 17'h08850, 17'h0ac50, 17'h0c850, 17'h0ec50};
  rfs_supervisor DUT (.clk(clk), .rst(rst), .regulator_enable_in(en), .low_power_state_n(psi),
    .deeper_sleep_select(ds), .phase_config(cfg), .comp_range(comp), .droop_above_oc(oc),
    .droop_above_woc(woc), .phase_current_sense_imbal(imb), .out_under_target(uv),
    .out_over_target(ov), .out_above_1v55(above), .out_below_0v85(below),
    .ntc_below_1v18(ntc), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hsel(hsel), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pwm_tristate(pwm), .low_side_force_on(ls), .power_good_out(pg),
    .thermal_throttle_n(ttN), .aux_feedback_node_sw(aux), .oc_threshold(thr),
    .active_phases(ph), .diode_emulation(de), .irq(irq));
  rfs_vout_model u_vout (.clk(clk), .hsShort(hsShort), .low_side_force_on(ls),
    .out_above_1v55(above), .out_below_0v85(below));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task print_verdict;
    $display("Compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task waitrdy;
    n = 0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin err_total++; print_verdict; end
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= a; hsize <= 3'h2;
    waitrdy;
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    waitrdy;
    q = hrdata;
  endtask
  task restart;
    en <= 0; tick(3); en <= 1; tick(20);
  endtask
  initial begin
    {rst, psi, cfg} = 4'hf;
    {en, ds, oc, woc, imb, uv, ov, ntc, hsShort, hwrite, hsel, htrans, comp} = 0;
    {haddr, hwdata, hsize, err_total, cmp_count} = 0;
    tick(8); rst <= 0; tick(1); #1;
    `CHK({pwm, pg, ttN, ls, irq, thr}, 14'h2800, "reset outputs")
    $display("reset done");
    for (i = 0; i < 12; i++) begin
      tick(1); cfg <= rows[i][16:15]; psi <= rows[i][14]; ds <= rows[i][13]; restart; #1;
      `CHK({ph, de, aux, thr}, rows[i][12:0], "mode row")
    end
    $display("mode table done");
    comp <= 3'h3; cfg <= 2'h3; psi <= 1; ds <= 0; restart; comp <= 3'h0; tick(4); #1;
    `CHK({thr, pwm}, 10'h1b0, "fitted range threshold")
    oc <= 1; tick(11990); oc <= 0; tick(1); oc <= 1; tick(11995); #1;
    `CHK(pwm, 1'b0, "early overcurrent")
    tick(10); #1;
    `CHK({pwm, pg, irq}, 3'h4, "overcurrent latch")
    oc <= 0; ahb(0, 32'h8, 0); #1;
    `CHK({q, irq}, 33'h2, "overcurrent event")
    restart; #1;
    `CHK(pwm, 1'b0, "fault cleared by enable")
    $display("overcurrent done");
    woc <= 1; tick(3); #1;
    `CHK({pwm, pg}, 2'h2, "way overcurrent")
    woc <= 0; hsShort <= 1; p = 0; n = 0;
    for (i = 0; i < 300; i++) begin
      @(posedge clk); #1;
      if (ls && !p) n++;
      p = ls;
      if (i == 100) en <= 0;
      if (i == 150) en <= 1;
    end
    `CHK(n > 2, 1'b1, "force sequence repeats")
    hsShort <= 0; tick(40); #1;
    `CHK({ls, pg, pwm}, 3'h1, "overvoltage latch held")
    rst <= 1; tick(2); rst <= 0; tick(20); #1;
    `CHK({ls, pwm}, 2'h0, "supply reset clears")
    $display("overvoltage done");
    ntc <= 1; tick(3); #1;
    `CHK({ttN, pwm, ls, irq}, 4'h0, "throttle only")
    ahb(0, 32'h8, 0); ntc <= 0; #1;
    `CHK({q, irq}, 33'h80, "throttle event read clears")
    ahb(1, 32'hc, 32'h40); ahb(0, 32'hc, 0);
    `CHK(q, 32'h40, "mask readback")
    ntc <= 1; tick(3); #1;
    `CHK({ttN, irq}, 2'h1, "masked event")
    ahb(0, 32'h20, 0);
    `CHK(q, 32'h0, "unmapped read")
    $display("interrupt done");
    print_verdict;
  end
endmodule
`default_nettype wire
